/* File: hdl/spi_baud_gen.sv */
// spi_baud_gen: half-period strobe of the master shift clock
// assumes the bus clock; rate and scale are held stable during a frame
`timescale 1ns/100ps
module spi_baud_gen
  import spi_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // control
  input  wire logic              run_in,
  input  wire logic [RATE_W-1:0] rate_in,
  input  wire logic [1:0]        scale_in,
  // strobe
  output logic                   half_tick_out
);
  logic [HALF_W-1:0] cnt_q;
  logic [HALF_W-1:0] cnt_d;
  wire  [HALF_W-1:0] half_len;
  wire               at_end;

  // full ratio is twice half_len: 2 .. 4096
  assign half_len      = HALF_W'(({4'h0, rate_in} + 12'h001) << scale_in);
  assign at_end        = (cnt_q == HALF_W'(half_len - 12'h001));
  assign half_tick_out = run_in & at_end;
  assign cnt_d         = (!run_in || at_end) ? '0 : HALF_W'(cnt_q + 12'h001);

  always_ff @(posedge clock_in) begin
    if (reset_in) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule

/* File: hdl/spi_core.sv */
// spi_core: one-channel serial peripheral unit, master or slave
// assumes pins arrive asynchronous; config ports come from the bus clock domain
`timescale 1ns/100ps
module spi_core
  import spi_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // control
  input  wire logic              enable_in,
  input  wire logic              master_in,
  input  wire logic              loopback_in,
  input  wire logic              output_pin_mode_bit_in,
  input  wire logic              clock_autostop_enable_in,
  input  wire logic              parity_en_in,
  input  wire logic              parity_odd_in,
  input  wire logic              mosi_idle_in,
  input  wire logic              init_in,
  input  wire logic [RATE_W-1:0] rate_in,
  input  wire logic [2:0]        seq_last_in,
  // command table
  input  wire logic              cmd_we_in,
  input  wire logic [2:0]        cmd_idx_in,
  input  wire spi_cmd_t          cmd_in,
  output logic [2:0]             cmd_ptr_out,
  // transmit buffer
  input  wire logic              tx_write_in,
  input  wire logic [WORD_W-1:0] tx_data_in,
  output logic                   tx_ready_out,
  // receive buffer
  input  wire logic              rx_read_in,
  output logic [WORD_W-1:0]      rx_data_out,
  output logic                   rx_valid_out,
  // status
  input  wire spi_err_t          err_clear_in,
  output spi_err_t               serial_status_register_out,
  // requests
  output logic                   rx_full_irq_out,
  output logic                   tx_empty_irq_out,
  output logic                   error_irq_out,
  output logic                   idle_irq_out,
  // pins
  input  wire logic              shift_clock_pin_in,
  output logic                   shift_clock_pin_out,
  output logic                   shift_clock_pin_oe_out,
  input  wire logic              mosi_pin_in,
  output logic                   mosi_pin_out,
  output logic                   mosi_pin_oe_out,
  input  wire logic              miso_pin_in,
  output logic                   miso_pin_out,
  output logic                   miso_pin_oe_out,
  input  wire logic              slave_select_n_in,
  output logic [SSL_W-1:0]       slave_select_lines_out,
  output logic                   slave_select_lines_oe_out
);
  // pin synchronisers
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic       sck_s3_q;
  logic       ss_s3_q;
  wire        sck_s  = pin_s2_q[3];
  wire        ss_n_s = pin_s2_q[2];
  wire        mosi_s = pin_s2_q[1];
  wire        miso_s = pin_s2_q[0];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_s1_q <= SYNC_RST;
      pin_s2_q <= SYNC_RST;
      sck_s3_q <= 1'b0;
      ss_s3_q  <= 1'b1;
    end else begin
      pin_s1_q <= {shift_clock_pin_in, slave_select_n_in, mosi_pin_in, miso_pin_in};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= sck_s;
      ss_s3_q  <= ss_n_s;
    end
  end

  // phases of 3+ bus clocks leave every slave edge visible after sync
  wire sck_edge = sck_s ^ sck_s3_q;
  wire ss_fall  = ss_s3_q & ~ss_n_s;

  // command table
  spi_cmd_t   cmd_mem [NCMD];
  logic [2:0] cmd_ptr_q;
  spi_cmd_t   cur;

  assign cur         = master_in ? cmd_mem[cmd_ptr_q] : cmd_mem[0];
  assign cmd_ptr_out = cmd_ptr_q;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < NCMD; i++) begin
        cmd_mem[i] <= CMD_RST;
      end
    end else if (cmd_we_in) begin
      cmd_mem[cmd_idx_in] <= cmd_in;
    end
  end

  // state
  spi_state_t        state_q;
  logic [2:0]        dly_q;
  logic [5:0]        half_q;
  logic              sck_q;
  logic              out_q;
  logic              txp_q;
  logic              rxp_q;
  logic [WORD_W-1:0] tx_sh_q;
  logic [WORD_W-1:0] rx_sh_q;
  logic [WORD_W-1:0] rx_sh_d;
  logic [SSL_W-1:0]  ssl_q;
  spi_err_t          err_q;
  logic              tick;

  // buffers: 128 bits each way, plus the shift words
  logic [WORD_W-1:0] tx_mem [BUF_WORDS];
  logic [WORD_W-1:0] rx_mem [BUF_WORDS];
  logic [1:0]        tx_wp_q;
  logic [1:0]        tx_rp_q;
  logic [1:0]        rx_wp_q;
  logic [1:0]        rx_rp_q;
  logic [2:0]        tx_cnt_q;
  logic [2:0]        rx_cnt_q;

  wire tx_empty = (tx_cnt_q == 3'h0);
  wire rx_full  = (rx_cnt_q == CNT_FULL);
  wire run      = enable_in & ~init_in;
  wire modf     = run & master_in & ~ss_n_s;
  wire stall    = clock_autostop_enable_in & rx_full;
  wire go       = run & master_in & ~err_q.mode_fault & ~tx_empty & ~stall;

  // step decode shared by master and slave
  wire        in_shift = (state_q == ST_SHIFT);
  wire        step     = in_shift & (master_in ? tick : sck_edge);
  wire        smp_edge = (half_q[0] == cur.cpha);
  wire        last     = (half_q == {cur.len, 1'b1});
  wire [5:0]  half_p1  = 6'(half_q + 6'h01);
  wire [4:0]  chg_idx  = half_p1[5:1];
  wire [4:0]  smp_idx  = cur.lsb_first ? half_q[5:1] : 5'(cur.len - half_q[5:1]);
  wire        txp_n    = txp_q ^ out_q;
  wire        par_slot = parity_en_in & (chg_idx == cur.len);
  wire        chg_bit  = par_slot ? (txp_n ^ parity_odd_in)
                                  : spi_bit_at(tx_sh_q, chg_idx, cur);
  wire        rx_bit   = loopback_in ? out_q : (master_in ? miso_s : mosi_s);
  wire        rxp_n    = rxp_q ^ rx_bit;
  wire        done     = step & last;
  wire        par_bad  = parity_en_in & ((smp_edge ? rxp_n : rxp_q) != parity_odd_in);
  wire        m_load   = (state_q == ST_IDLE) & go;
  wire        s_load   = run & ~master_in & ss_fall;
  wire        load     = m_load | s_load;
  wire [WORD_W-1:0] load_word = tx_empty ? '0 : tx_mem[tx_rp_q];
  wire        neg_end  = (state_q == ST_NEG) & tick & (dly_q == 3'h0);

  always_comb begin
    rx_sh_d = rx_sh_q;
    if (step && smp_edge) rx_sh_d[smp_idx] = rx_bit;
  end

  spi_baud_gen u_baud (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .run_in        (master_in && state_q != ST_IDLE),
    .rate_in       (rate_in),
    .scale_in      (cur.scale),
    .half_tick_out (tick)
  );

  // transmit buffer
  wire tx_push = tx_write_in & (tx_cnt_q != CNT_FULL);
  wire tx_pop  = load & ~tx_empty;
  always_ff @(posedge clock_in) begin
    if (reset_in || init_in) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) tx_mem[tx_wp_q] <= tx_data_in;
      tx_wp_q  <= 2'(tx_wp_q + {1'b0, tx_push});
      tx_rp_q  <= 2'(tx_rp_q + {1'b0, tx_pop});
      tx_cnt_q <= 3'(tx_cnt_q + {2'b00, tx_push} - {2'b00, tx_pop});
    end
  end

  // receive buffer; a frame into a full buffer is dropped
  wire rx_push = done & ~rx_full;
  wire rx_pop  = rx_read_in & (rx_cnt_q != 3'h0);
  always_ff @(posedge clock_in) begin
    if (reset_in || init_in) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) rx_mem[rx_wp_q] <= rx_sh_d;
      rx_wp_q  <= 2'(rx_wp_q + {1'b0, rx_push});
      rx_rp_q  <= 2'(rx_rp_q + {1'b0, rx_pop});
      rx_cnt_q <= 3'(rx_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop});
    end
  end

  // error flags: a set in the clearing cycle wins
  spi_err_t err_set;
  assign err_set = '{mode_fault: modf, overrun: done & rx_full,
                     parity: done & par_bad,
                     underrun_error_flag: s_load & tx_empty};
  always_ff @(posedge clock_in) begin
    if (reset_in || init_in) err_q <= '0;
    else err_q <= (err_q & ~err_clear_in) | err_set;
  end

  // sequencer and shifter
  always_ff @(posedge clock_in) begin
    if (reset_in || init_in || !run || modf) begin
      state_q   <= ST_IDLE;
      cmd_ptr_q <= '0;
      dly_q     <= '0;
      half_q    <= '0;
      sck_q     <= 1'b0;
      out_q     <= 1'b0;
      txp_q     <= 1'b0;
      rxp_q     <= 1'b0;
      tx_sh_q   <= '0;
      rx_sh_q   <= '0;
      ssl_q     <= SSL_IDLE;
    end else begin
      rx_sh_q <= rx_sh_d;
      if (load) begin
        tx_sh_q <= load_word;
        out_q   <= spi_bit_at(load_word, 5'h00, cur);
        half_q  <= '0;
        txp_q   <= 1'b0;
        rxp_q   <= 1'b0;
        dly_q   <= cur.clk_dly;
      end
      if (step) begin
        sck_q  <= ~sck_q;
        half_q <= half_p1;
        if (smp_edge) rxp_q <= rxp_n;
        else begin
          out_q <= chg_bit;
          txp_q <= txp_n;
        end
      end
      case (state_q)
        ST_IDLE: begin
          sck_q <= cur.cpol;
          if (s_load) state_q <= ST_SHIFT;
          else if (m_load) begin
            state_q <= ST_LEAD;
            ssl_q   <= ~cur.slave_select_lines;
          end else ssl_q <= SSL_IDLE;
        end
        ST_LEAD: begin
          if (tick && dly_q == 3'h0) state_q <= ST_SHIFT;
          else if (tick) dly_q <= 3'(dly_q - 3'h1);
        end
        ST_SHIFT: begin
          if (!master_in && ss_n_s) state_q <= ST_IDLE;
          else if (done && master_in) begin
            state_q <= ST_NEG;
            dly_q   <= cur.neg_dly;
          end else if (done) state_q <= ST_NEXT;
        end
        ST_NEG: begin
          if (neg_end) begin
            state_q   <= ST_NEXT;
            dly_q     <= cur.nxt_dly;
            if (!cur.burst) ssl_q <= SSL_IDLE;
            cmd_ptr_q <= (cmd_ptr_q == seq_last_in) ? 3'h0 : 3'(cmd_ptr_q + 3'h1);
          end else if (tick) dly_q <= 3'(dly_q - 3'h1);
        end
        ST_NEXT: begin
          if (!master_in) begin
            if (ss_n_s) state_q <= ST_IDLE;
          end else if (tick && dly_q == 3'h0) state_q <= ST_IDLE;
          else if (tick) dly_q <= 3'(dly_q - 3'h1);
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pins; open-drain only pulls clock and data pins low, select lines stay push-pull
  wire od       = output_pin_mode_bit_in;
  wire ssl_on   = (ssl_q != SSL_IDLE);
  wire mosi_val = ssl_on ? out_q : mosi_idle_in;
  wire m_drv    = run & master_in;
  wire s_drv    = run & ~master_in & (state_q != ST_IDLE);

  assign shift_clock_pin_out       = od ? 1'b0 : sck_q;
  assign shift_clock_pin_oe_out    = m_drv & (~od | ~sck_q);
  assign mosi_pin_out              = od ? 1'b0 : mosi_val;
  assign mosi_pin_oe_out           = m_drv & (~od | ~mosi_val);
  assign miso_pin_out              = od ? 1'b0 : out_q;
  assign miso_pin_oe_out           = s_drv & (~od | ~out_q);
  assign slave_select_lines_out    = ssl_q;
  assign slave_select_lines_oe_out = m_drv;

  // buffer and status outputs
  assign tx_ready_out               = (tx_cnt_q != CNT_FULL);
  assign rx_valid_out               = (rx_cnt_q != 3'h0);
  assign rx_data_out                = rx_mem[rx_rp_q];
  assign serial_status_register_out = err_q;
  assign rx_full_irq_out            = rx_full;
  assign tx_empty_irq_out           = run & tx_empty;
  assign error_irq_out              = |err_q;
  assign idle_irq_out               = run & (state_q == ST_IDLE) & tx_empty;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_rx_bound: assert property (rx_cnt_q <= CNT_FULL)
    else $error("receive count above 128 bits");
  a_write_starts: assert property (m_load |=> state_q == ST_LEAD ##0 ssl_on)
    else $error("tx write did not start a frame");
  a_seq_wrap: assert property (neg_end && cmd_ptr_q == seq_last_in |=> cmd_ptr_q == 3'h0)
    else $error("sequence did not wrap");
  a_mosi_idle: assert property (m_drv && !od && !ssl_on |-> mosi_pin_out == mosi_idle_in)
    else $error("mosi not at idle level");
  a_autostop_hold: assert property (master_in && stall && state_q == ST_IDLE |=> state_q == ST_IDLE)
    else $error("frame started with unread data");
  a_overrun_flag: assert property (done && rx_full && !init_in |=> err_q.overrun && rx_valid_out)
    else $error("overrun not flagged");
  a_underrun_flag: assert property (s_load && tx_empty && !init_in |=> error_irq_out)
    else $error("underrun not raised");
  a_open_drain: assert property (
      od |-> !(shift_clock_pin_oe_out && sck_q) && !(mosi_pin_oe_out && mosi_val))
    else $error("open-drain pin driven high");
  a_sck_rate: assert property (master_in && in_shift && $changed(sck_q) |-> $past(tick))
    else $error("shift clock moved off the divider");
  a_init_clear: assert property (init_in |=> state_q == ST_IDLE && tx_cnt_q == 3'h0)
    else $error("init left transfer state");

  c_master_frame: cover property (master_in && done);
  c_slave_frame: cover property (!master_in && done);
  c_burst: cover property (neg_end && cur.burst);
  c_loop_frame: cover property (loopback_in && done && !par_bad);
endmodule

/* File: include/spi_pkg.sv */
// spi_pkg: constants, types and helpers of the serial peripheral unit
// assumes one 20 MHz bus clock domain and no register bus
package spi_pkg;
  localparam int WORD_W    = 32;
  localparam int BUF_BITS  = 128;
  localparam int BUF_WORDS = BUF_BITS / WORD_W;
  localparam int NCMD      = 8;
  localparam int SSL_W     = 4;
  localparam int RATE_W    = 8;
  localparam int HALF_W    = 12;
  localparam int DIV_MIN   = 2;
  localparam int DIV_MAX   = 4096;
  localparam int SLV_DIV   = 6;
  localparam int SLV_PHASE = 3;

  localparam logic [SSL_W-1:0] SSL_IDLE = 4'hf;
  localparam logic [2:0]       CNT_FULL = 3'h4;
  localparam logic [3:0]       SYNC_RST = 4'h4;

  typedef struct packed {
    logic [SSL_W-1:0] slave_select_lines;
    logic [1:0]       scale;
    logic             cpol;
    logic             cpha;
    logic [4:0]       len;
    logic             lsb_first;
    logic             burst;
    logic [2:0]       clk_dly;
    logic [2:0]       neg_dly;
    logic [2:0]       nxt_dly;
  } spi_cmd_t;

  localparam spi_cmd_t CMD_RST = 24'he0_3800;

  typedef struct packed {
    logic mode_fault;
    logic overrun;
    logic parity;
    logic underrun_error_flag;
  } spi_err_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_SHIFT = 3'h3,
    ST_NEG   = 3'h2,
    ST_NEXT  = 3'h6
  } spi_state_t;

  function automatic logic spi_bit_at(logic [WORD_W-1:0] w, logic [4:0] i, spi_cmd_t c);
    spi_bit_at = c.lsb_first ? w[i] : w[5'(c.len - i)];
  endfunction
endpackage

/* File: tb/spi_core_tb.sv */
// spi_core_tb: self-checking bench of the serial peripheral unit
// assumes the slave model on the pins and a 20 MHz bus clock
`timescale 1ns/100ps
module spi_core_tb;
  import spi_pkg::*;
  logic              clk, rst, en, mst, lpb, od, ase, mosi_idle, init, cmd_we, tx_wr, rx_rd;
  logic              sck_b, mosi_b, ss_n, miso_m, par_en, par_odd;
  logic [RATE_W-1:0] rate;
  logic [2:0]        seq_last, cmd_idx, ptr;
  spi_cmd_t          cmd;
  spi_err_t          clr, stat;
  logic [WORD_W-1:0] tx_data, rx_data;
  logic              tx_rdy, rx_vld, rx_full, tx_empty, err_irq, idle_irq;
  logic              sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ssl_oe;
  logic [SSL_W-1:0]  ssl_o, sel_seen;
  logic [7:0]        got;
  wire               sck_w  = sck_oe ? sck_o : sck_b;
  wire               mosi_w = mosi_oe ? mosi_o : mosi_b;
  wire               miso_w = miso_oe ? miso_o : miso_m;
  wire [SSL_W-1:0]   ssl_w  = ssl_oe ? ssl_o : 4'hf;
  int                bad_count = 0;
  int                comparisons = 0;
  int                cycles = 0;

  spi_core i_spi_core (
    .clock_in(clk), .reset_in(rst), .enable_in(en), .master_in(mst), .loopback_in(lpb),
    .output_pin_mode_bit_in(od), .clock_autostop_enable_in(ase), .parity_en_in(par_en),
    .parity_odd_in(par_odd), .mosi_idle_in(mosi_idle), .init_in(init), .rate_in(rate),
    .seq_last_in(seq_last), .cmd_we_in(cmd_we), .cmd_idx_in(cmd_idx), .cmd_in(cmd),
    .cmd_ptr_out(ptr), .tx_write_in(tx_wr), .tx_data_in(tx_data), .tx_ready_out(tx_rdy),
    .rx_read_in(rx_rd), .rx_data_out(rx_data), .rx_valid_out(rx_vld),
    .err_clear_in(clr), .serial_status_register_out(stat), .rx_full_irq_out(rx_full),
    .tx_empty_irq_out(tx_empty), .error_irq_out(err_irq), .idle_irq_out(idle_irq),
    .shift_clock_pin_in(sck_w), .shift_clock_pin_out(sck_o), .shift_clock_pin_oe_out(sck_oe),
    .mosi_pin_in(mosi_w), .mosi_pin_out(mosi_o), .mosi_pin_oe_out(mosi_oe),
    .miso_pin_in(miso_w), .miso_pin_out(miso_o), .miso_pin_oe_out(miso_oe),
    .slave_select_n_in(ss_n), .slave_select_lines_out(ssl_o),
    .slave_select_lines_oe_out(ssl_oe)
  );

  spi_slave_model i_spi_slave_model (
    .sck_in(sck_w), .mosi_in(mosi_w), .sel_in(ssl_w), .miso_out(miso_m),
    .got_out(got), .sel_seen_out(sel_seen)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge clk);
    tx_data <= {24'h00_0000, b};
    tx_wr   <= 1'b1;
    @(posedge clk);
    tx_wr   <= 1'b0;
  endtask

  task automatic pop();
    @(posedge clk);
    rx_rd <= 1'b1;
    @(posedge clk);
    rx_rd <= 1'b0;
  endtask

  // 0: rx word held, 1: rx buffer full, 2: unit idle
  task automatic wait_for(input int which);
    int k;
    k = 0;
    while (k < 3000 && !((which == 0 && rx_vld === 1'b1) ||
           (which == 1 && rx_full === 1'b1) || (which == 2 && idle_irq === 1'b1))) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      bad_count++;
      $display("MISMATCH at %0t: wait %0d expired", $time, which);
    end
  endtask

  task automatic frame(input logic [7:0] b);
    push(b);
    tick(4);
    wait_for(2);
    @(negedge clk);
  endtask

  initial begin
    rst = 1'b1; en = 1'b1; mst = 1'b1; lpb = 1'b0; od = 1'b0; ase = 1'b0;
    mosi_idle = 1'b1; init = 1'b0; cmd_we = 1'b0; tx_wr = 1'b0; rx_rd = 1'b0;
    sck_b = 1'b0; mosi_b = 1'b1; ss_n = 1'b1; rate = 8'h03; seq_last = 3'h0;
    cmd_idx = 3'h0; cmd = CMD_RST; clr = 4'h0; tx_data = 32'h0000_0000;
    par_en = 1'b0; par_odd = 1'b0;
    tick(16);
    rst <= 1'b0;
    tick(4);
    @(negedge clk);
    check(ssl_o, 4'hf);
    check({tx_rdy, rx_vld}, 2'h2);
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      @(posedge clk);
      od        <= v[1];
      mosi_idle <= v[0];
      tick(3);
      @(negedge clk);
      check(mosi_w, v[0]);
      if (v[1]) check(mosi_o, 1'b0);
    end
    @(posedge clk);
    od <= 1'b0;
    $display("test idle pins done");
    frame(8'ha5);
    check(got, 8'ha5);
    check(sel_seen, 4'h1);
    check(rx_data[7:0], 8'h96);
    check(ptr, 3'h0);
    pop();
    $display("test master frame done");
    @(posedge clk);
    cmd.lsb_first <= 1'b1;
    cmd.slave_select_lines       <= 4'hd;
    cmd_idx       <= 3'h1;
    cmd_we        <= 1'b1;
    seq_last      <= 3'h1;
    @(posedge clk);
    cmd_we <= 1'b0;
    frame(8'hc1);
    check(ptr, 3'h1);
    pop();
    frame(8'hc1);
    check(got, 8'h83);
    check(sel_seen, 4'h2);
    check(rx_data[7:0], 8'h69);
    check(ptr, 3'h0);
    pop();
    $display("test sequencer done");
    @(posedge clk);
    lpb      <= 1'b1;
    ase      <= 1'b1;
    seq_last <= 3'h0;
    for (int i = 1; i < 5; i++) push(8'(i * 17));
    wait_for(1);
    @(negedge clk);
    check(rx_full, 1'b1);
    push(8'h55);
    tick(300);
    @(negedge clk);
    check(stat, 4'h0);
    check(tx_empty, 1'b0);
    check(rx_data[7:0], 8'h11);
    pop();
    tick(4);
    wait_for(1);
    @(negedge clk);
    check(rx_data[7:0], 8'h22);
    check(tx_empty, 1'b1);
    @(posedge clk);
    ase <= 1'b0;
    push(8'h66);
    tick(300);
    @(negedge clk);
    check(stat, 4'h4);
    check(err_irq, 1'b1);
    @(posedge clk);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
    tick(2);
    @(negedge clk);
    check({rx_vld, stat}, 5'h00);
    $display("test buffers done");
    @(posedge clk);
    lpb     <= 1'b0;
    par_en  <= 1'b1;
    par_odd <= 1'b1;
    frame(8'h5a);
    check(stat, 4'h2);
    check(rx_data[7:0], 8'h96);
    pop();
    @(posedge clk);
    par_en <= 1'b0;
    clr    <= 4'h2;
    @(posedge clk);
    clr <= 4'h0;
    $display("test parity done");
    @(posedge clk);
    lpb  <= 1'b0;
    ss_n <= 1'b0;
    tick(10);
    @(negedge clk);
    check(stat, 4'h8);
    check(err_irq, 1'b1);
    @(posedge clk);
    ss_n <= 1'b1;
    tick(6);
    clr <= 4'h8;
    @(posedge clk);
    clr <= 4'h0;
    tick(2);
    @(negedge clk);
    check(stat, 4'h0);
    $display("test mode fault done");
    @(posedge clk);
    mst  <= 1'b0;
    ss_n <= 1'b0;
    tick(10);
    // 400 ns shift clock, four bus clocks per phase
    repeat (16) begin
      @(posedge clk);
      sck_b <= ~sck_b;
      tick(3);
    end
    tick(10);
    @(negedge clk);
    check({miso_oe, miso_o}, 2'h2);
    @(posedge clk);
    ss_n <= 1'b1;
    tick(10);
    @(negedge clk);
    check(rx_vld, 1'b1);
    check(rx_data[7:0], 8'hff);
    check(stat, 4'h1);
    check(err_irq, 1'b1);
    $display("test slave done");
    conclude();
  end
endmodule

/* File: tb/spi_slave_model.sv */
// spi_slave_model: behavioural external slave device, clock mode 0, msb first
// assumes select, clock and data wires already resolved by the bench
`timescale 1ns/100ps
module spi_slave_model #(
  parameter logic [7:0] REPLY = 8'h96
) (
  // pins
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic [3:0] sel_in,
  output logic            miso_out,
  // observation
  output logic [7:0]      got_out,
  output logic [3:0]      sel_seen_out
);
  logic [7:0] shift_q;
  wire        sel_w = (sel_in != 4'hf);

  initial begin
    miso_out     = 1'b0;
    got_out      = 8'h00;
    sel_seen_out = 4'hf;
    shift_q      = REPLY;
  end

  // reply loaded as soon as a select line falls while all lines were released
  always @(posedge sel_w) begin
    shift_q      = REPLY;
    miso_out     = REPLY[7];
    sel_seen_out = sel_in;
  end

  // released line never keeps its last value
  always @(negedge sel_w) miso_out = ~miso_out;

  always @(posedge sck_in) if (sel_w) got_out = {got_out[6:0], mosi_in};

  always @(negedge sck_in) if (sel_w) begin
    shift_q  = {shift_q[6:0], 1'b0};
    miso_out = shift_q[7];
  end
endmodule
